// [aie_execute.sv]
`timescale 1ns/100ps
`default_nettype none
module aie_execute #(
  parameter int WDT_W   = aie_pkg::AIE_WDT_W,
  parameter int RF_N    = aie_pkg::AIE_RF_N
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire aie_pkg::aie_apb_req_t apb_req,
  output var  aie_pkg::aie_apb_rsp_t apb_rsp,
  // observation
  output logic                    wdt_expired
);
  import aie_pkg::*;

  aie_state_t        state_r;
  aie_cmd_t          cmd_r;
  logic [7:0]        working_accumulator_r;
  logic [7:0]        rf_r [RF_N];
  logic              carry_r;
  logic              half_carry_flag_r;
  logic              zero_r;
  logic              overflow_flag_r;
  logic              timeout_flag_r;
  logic              powerdown_flag_r;
  logic              gie_r;
  logic [10:0]       pc_r;
  logic [10:0]       link_r;
  logic [WDT_W-1:0]  wdt_r;
  logic [15:0]       flush_cnt_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [31:0]       prdata_r;
  logic              wdt_expired_r;

  // apb decode
  logic              access_phase;
  logic              done;
  logic              wr_en;
  logic              hit;
  logic              rf_hit;
  logic [2:0]        rf_idx;
  logic [31:0]       rd_val;
  logic              launch;
  logic [7:0]        st_byte;

  assign access_phase = apb_req.psel & apb_req.penable;
  assign done      = access_phase & pready_r;
  assign wr_en     = done & apb_req.pwrite & ~pslverr_r;
  assign rf_hit    = (apb_req.paddr >= AIE_OFF_RF) &&
                     (apb_req.paddr < AIE_OFF_RF + 8'(RF_N * 4)) &&
                     (apb_req.paddr[1:0] == 2'b00);
  assign rf_idx    = 3'(apb_req.paddr[7:2] - AIE_OFF_RF[7:2]);
  assign launch    = wr_en && (apb_req.paddr == AIE_OFF_CMD);
  assign st_byte   = {1'b0, gie_r, powerdown_flag_r, timeout_flag_r,
                      overflow_flag_r, zero_r, half_carry_flag_r, carry_r};

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (apb_req.paddr)
      AIE_OFF_CMD:    rd_val = cmd_r;
      AIE_OFF_ACCUM:  rd_val = {24'h00_0000, working_accumulator_r};
      AIE_OFF_STATUS: rd_val = {23'h00_0000, (state_r != AIE_S_IDLE), st_byte};
      AIE_OFF_PC:     rd_val = {21'h00_0000, pc_r};
      AIE_OFF_WDT:    rd_val = 32'(wdt_r);
      AIE_OFF_LINK:   rd_val = {21'h00_0000, link_r};
      AIE_OFF_FLUSH:  rd_val = {16'h0000, flush_cnt_r};
      default: begin
        if (rf_hit) begin
          rd_val = {24'h00_0000, rf_r[rf_idx]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // one wait state per access; stalls while an instruction is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      if (access_phase && !pready_r && state_r == AIE_S_IDLE) begin
        pready_r  <= 1'b1;
        pslverr_r <= ~hit;
        prdata_r  <= apb_req.pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // execute datapath
  aie_op_t    op;
  logic [7:0] src;
  logic [7:0] opb;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic       wr_acc;
  logic       wr_reg;
  logic       upd_z;
  logic       upd_arith;
  logic       upd_c;
  logic       new_c;
  logic       two_cycle;
  logic       cin;

  assign op  = aie_op_t'(cmd_r.op);
  assign src = rf_r[cmd_r.rsel];

  always_comb begin
    cin       = 1'b0;
    opb       = src;
    res       = 8'h00;
    wr_acc    = 1'b0;
    wr_reg    = 1'b0;
    upd_z     = 1'b0;
    upd_arith = 1'b0;
    upd_c     = 1'b0;
    new_c     = carry_r;
    two_cycle = 1'b0;
    case (op)
      AIE_OP_ADD, AIE_OP_ADDC: begin
        cin       = (op == AIE_OP_ADDC) ? carry_r : 1'b0;
        wr_acc    = ~cmd_r.to_reg;
        wr_reg    = cmd_r.to_reg;
        upd_arith = 1'b1;
      end
      AIE_OP_ADDI: begin
        opb       = cmd_r.imm;
        wr_acc    = 1'b1;
        upd_arith = 1'b1;
      end
      AIE_OP_AND, AIE_OP_ANDI: begin
        opb    = (op == AIE_OP_ANDI) ? cmd_r.imm : src;
        res    = working_accumulator_r & opb;
        wr_acc = (op == AIE_OP_ANDI) | ~cmd_r.to_reg;
        wr_reg = (op == AIE_OP_AND) & cmd_r.to_reg;
        upd_z  = 1'b1;
      end
      AIE_OP_OR, AIE_OP_ORI: begin
        opb    = (op == AIE_OP_ORI) ? cmd_r.imm : src;
        res    = working_accumulator_r | opb;
        wr_acc = (op == AIE_OP_ORI) | ~cmd_r.to_reg;
        wr_reg = (op == AIE_OP_OR) & cmd_r.to_reg;
        upd_z  = 1'b1;
      end
      AIE_OP_CALL, AIE_OP_JUMP, AIE_OP_RET, AIE_OP_IRET: begin
        two_cycle = 1'b1;
      end
      AIE_OP_RETV: begin
        two_cycle = 1'b1;
        res       = cmd_r.imm;
        wr_acc    = 1'b1;
      end
      AIE_OP_CLR: begin
        res    = 8'h00;
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
        upd_z  = 1'b1;
      end
      AIE_OP_CLRB: begin
        res    = src & ~(8'h01 << cmd_r.bsel);
        wr_reg = 1'b1;
      end
      AIE_OP_COM: begin
        res    = ~src;
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
        upd_z  = 1'b1;
      end
      AIE_OP_DEC: begin
        res    = src - 8'h01;
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
        upd_z  = 1'b1;
      end
      AIE_OP_INC: begin
        res    = src + 8'h01;
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
        upd_z  = 1'b1;
      end
      AIE_OP_LDA: begin
        res    = src;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      AIE_OP_STA: begin
        res    = working_accumulator_r;
        wr_reg = 1'b1;
      end
      AIE_OP_LDI: begin
        res    = cmd_r.imm;
        wr_acc = 1'b1;
      end
      AIE_OP_RLC: begin
        res    = {src[6:0], carry_r};
        new_c  = src[7];
        upd_c  = 1'b1;
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
      end
      AIE_OP_RRC: begin
        res    = {carry_r, src[7:1]};
        new_c  = src[0];
        upd_c  = 1'b1;
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
      end
      AIE_OP_RL: begin
        res    = {src[6:0], src[7]};
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
      end
      AIE_OP_RR: begin
        res    = {src[0], src[7:1]};
        wr_acc = ~cmd_r.to_reg;
        wr_reg = cmd_r.to_reg;
      end
      default: begin
        res = 8'h00;
      end
    endcase
    sum9 = {1'b0, working_accumulator_r} + {1'b0, opb} + {8'h00, cin};
    sum5 = {1'b0, working_accumulator_r[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    if (upd_arith) begin
      res   = sum9[7:0];
      new_c = sum9[8];
    end
  end

  logic exec_now;
  assign exec_now = (state_r == AIE_S_EXEC);

  // sequencer: one-cycle instructions finish in the exec cycle, transfers add a flush cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= AIE_S_IDLE;
      cmd_r   <= '0;
    end else begin
      case (state_r)
        AIE_S_IDLE: begin
          if (launch) begin
            cmd_r   <= apb_req.pwdata;
            state_r <= AIE_S_EXEC;
          end
        end
        AIE_S_EXEC: begin
          state_r <= two_cycle ? AIE_S_FLUSH : AIE_S_IDLE;
        end
        AIE_S_FLUSH: begin
          state_r <= AIE_S_IDLE;
        end
        default: begin
          state_r <= AIE_S_IDLE;
        end
      endcase
    end
  end

  // the prefetched word is thrown away in the second cycle of a transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_cnt_r <= 16'h0000;
    end else if (state_r == AIE_S_FLUSH) begin
      flush_cnt_r <= flush_cnt_r + 16'h0001;
    end
  end

  // accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_accumulator_r <= AIE_ACCUM_RST;
    end else if (exec_now && wr_acc) begin
      working_accumulator_r <= res;
    end else if (wr_en && apb_req.paddr == AIE_OFF_ACCUM) begin
      working_accumulator_r <= apb_req.pwdata[7:0];
    end
  end

  // data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RF_N; i++) begin
        rf_r[i] <= 8'h00;
      end
    end else if (exec_now && wr_reg) begin
      rf_r[cmd_r.rsel] <= res;
    end else if (wr_en && rf_hit) begin
      rf_r[rf_idx] <= apb_req.pwdata[7:0];
    end
  end

  // arithmetic and zero flags; transfers, STA and LDI leave them alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_r           <= AIE_STATUS_RST[AIE_ST_C];
      half_carry_flag_r <= AIE_STATUS_RST[AIE_ST_HALF];
      zero_r            <= AIE_STATUS_RST[AIE_ST_Z];
      overflow_flag_r   <= AIE_STATUS_RST[AIE_ST_OVF];
    end else if (exec_now) begin
      if (upd_arith) begin
        carry_r           <= new_c;
        half_carry_flag_r <= sum5[4];
        overflow_flag_r   <= (working_accumulator_r[7] == opb[7]) &&
                             (sum9[7] != working_accumulator_r[7]);
      end
      if (upd_c) begin
        carry_r <= new_c;
      end
      if (upd_z || upd_arith) begin
        zero_r <= (res == 8'h00);
      end
    end else if (wr_en && apb_req.paddr == AIE_OFF_STATUS) begin
      carry_r           <= apb_req.pwdata[AIE_ST_C];
      half_carry_flag_r <= apb_req.pwdata[AIE_ST_HALF];
      zero_r            <= apb_req.pwdata[AIE_ST_Z];
      overflow_flag_r   <= apb_req.pwdata[AIE_ST_OVF];
    end
  end

  // program counter, link and interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r   <= AIE_PC_RST;
      link_r <= AIE_PC_RST;
      gie_r  <= AIE_STATUS_RST[AIE_ST_GIE];
    end else if (exec_now) begin
      case (op)
        AIE_OP_CALL: begin
          link_r <= pc_r + 11'h001;
          pc_r   <= cmd_r.target;
        end
        AIE_OP_JUMP: begin
          pc_r <= cmd_r.target;
        end
        AIE_OP_RET, AIE_OP_RETV: begin
          pc_r <= link_r;
        end
        AIE_OP_IRET: begin
          pc_r  <= link_r;
          gie_r <= 1'b1;
        end
        default: begin
          pc_r <= pc_r + 11'h001;
        end
      endcase
    end else if (wr_en) begin
      if (apb_req.paddr == AIE_OFF_PC) begin
        pc_r <= apb_req.pwdata[10:0];
      end
      if (apb_req.paddr == AIE_OFF_LINK) begin
        link_r <= apb_req.pwdata[10:0];
      end
      if (apb_req.paddr == AIE_OFF_STATUS) begin
        gie_r <= apb_req.pwdata[AIE_ST_GIE];
      end
    end
  end

  // watchdog: free-running, expiry drops the timeout flag
  logic wdt_clr;
  logic wdt_wrap;
  assign wdt_clr  = exec_now && (op == AIE_OP_WDTC);
  assign wdt_wrap = &wdt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_r            <= '0;
      timeout_flag_r   <= AIE_STATUS_RST[AIE_ST_TMO];
      powerdown_flag_r <= AIE_STATUS_RST[AIE_ST_PWD];
      wdt_expired_r    <= 1'b0;
    end else begin
      wdt_expired_r <= 1'b0;
      if (wdt_clr) begin
        wdt_r            <= '0;
        timeout_flag_r   <= 1'b1;
        powerdown_flag_r <= 1'b1;
      end else begin
        wdt_r <= wdt_r + WDT_W'(1);
        if (wdt_wrap) begin
          timeout_flag_r <= 1'b0;
          wdt_expired_r  <= 1'b1;
        end
      end
    end
  end

  assign apb_rsp.pready  = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign apb_rsp.prdata  = prdata_r;
  assign wdt_expired     = wdt_expired_r;

endmodule
`default_nettype wire

// [aie_pkg.sv]
// Function
// - register plus accumulator add, carry optional, all arithmetic flags
// - immediate add into accumulator, arithmetic flags
// - and with register or immediate, zero flag only
// - or with register or immediate, zero flag only
// - call takes two cycles, flags unchanged
// - jump takes two cycles, flags unchanged
// - return two cycles, value variant loads accumulator
// - interrupt return two cycles, sets interrupt enable
// - clear accumulator or register, sets zero flag
// - bit clear touches one bit, no flags
// - watchdog clear resets counter, sets timeout, powerdown
// - complement register, zero flag
// - decrement register, zero flag only
// - increment register, zero flag only
// - load accumulator from register, zero flag
// - store accumulator, load immediate, flags unchanged
// - rotate left through carry
// - rotate right through carry
// - rotate left without carry, no flags
// - rotate right without carry, no flags
package aie_pkg;

  // register byte offsets
  localparam logic [7:0] AIE_OFF_CMD    = 8'h00;
  localparam logic [7:0] AIE_OFF_ACCUM  = 8'h04;
  localparam logic [7:0] AIE_OFF_STATUS = 8'h08;
  localparam logic [7:0] AIE_OFF_PC     = 8'h0c;
  localparam logic [7:0] AIE_OFF_WDT    = 8'h10;
  localparam logic [7:0] AIE_OFF_LINK   = 8'h14;
  localparam logic [7:0] AIE_OFF_FLUSH  = 8'h18;
  localparam logic [7:0] AIE_OFF_RF     = 8'h20;

  // status bit positions
  localparam int AIE_ST_C    = 0;
  localparam int AIE_ST_HALF = 1;
  localparam int AIE_ST_Z    = 2;
  localparam int AIE_ST_OVF  = 3;
  localparam int AIE_ST_TMO  = 4;
  localparam int AIE_ST_PWD  = 5;
  localparam int AIE_ST_GIE  = 6;
  localparam int AIE_ST_BUSY = 8;

  localparam logic [6:0]  AIE_STATUS_RST = 7'h30;
  localparam logic [7:0]  AIE_ACCUM_RST  = 8'h00;
  localparam logic [10:0] AIE_PC_RST     = 11'h000;
  localparam int          AIE_PC_W       = 11;
  localparam int          AIE_WDT_W      = 16;
  localparam int          AIE_RF_N       = 8;

  // cycles per instruction
  localparam int AIE_CYC_ONE = 1;
  localparam int AIE_CYC_TWO = 2;

  typedef enum logic [4:0] {
    AIE_OP_NOP  = 5'h00, AIE_OP_ADD  = 5'h01, AIE_OP_ADDC = 5'h02,
    AIE_OP_ADDI = 5'h03, AIE_OP_AND  = 5'h04, AIE_OP_ANDI = 5'h05,
    AIE_OP_OR   = 5'h06, AIE_OP_ORI  = 5'h07, AIE_OP_CALL = 5'h08,
    AIE_OP_JUMP = 5'h09, AIE_OP_RET  = 5'h0a, AIE_OP_RETV = 5'h0b,
    AIE_OP_IRET = 5'h0c, AIE_OP_CLR  = 5'h0d, AIE_OP_CLRB = 5'h0e,
    AIE_OP_WDTC = 5'h0f, AIE_OP_COM  = 5'h10, AIE_OP_DEC  = 5'h11,
    AIE_OP_INC  = 5'h12, AIE_OP_LDA  = 5'h13, AIE_OP_STA  = 5'h14,
    AIE_OP_LDI  = 5'h15, AIE_OP_RLC  = 5'h16, AIE_OP_RRC  = 5'h17,
    AIE_OP_RL   = 5'h18, AIE_OP_RR   = 5'h19
  } aie_op_t;

  // command word written to the command register
  typedef struct packed {
    logic        pad;
    logic [10:0] target;
    logic [7:0]  imm;
    logic [2:0]  rsel;
    logic [2:0]  bsel;
    logic        to_reg;
    logic [4:0]  op;
  } aie_cmd_t;

  typedef enum logic [2:0] {
    AIE_S_IDLE  = 3'b001,
    AIE_S_EXEC  = 3'b010,
    AIE_S_FLUSH = 3'b100
  } aie_state_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } aie_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } aie_apb_rsp_t;

endpackage

// [aie_execute_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module aie_execute_asserts #(
  parameter int WDT_W = aie_pkg::AIE_WDT_W,
  parameter int RF_N  = aie_pkg::AIE_RF_N
) (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // bus and observation
  input wire aie_pkg::aie_apb_req_t apb_req,
  input wire aie_pkg::aie_apb_rsp_t apb_rsp,
  input wire logic                  wdt_expired
);
  import aie_pkg::*;

  logic bad_addr;

  // holes in the map and byte offsets inside a word are refused alike
  assign bad_addr = (apb_req.paddr[1:0] != 2'b00) || (apb_req.paddr == 8'h1c) ||
                    (apb_req.paddr > 8'h3c);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  sequence s_start;
    $rose(apb_req.psel && apb_req.penable);
  endsequence

  chk_answer_bound: assert property (s_start |-> ##[1:3] apb_rsp.pready)
    else $error("access phase not answered in time");
  chk_ready_access: assert property (apb_rsp.pready |-> s_access)
    else $error("pready outside an access phase");
  chk_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held longer than one cycle");
  chk_err_unmapped: assert property (apb_rsp.pready && bad_addr |->
                                     apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (apb_rsp.pready && !bad_addr |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  chk_err_only: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  chk_write_zero: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
    else $error("read data on a write");
  chk_read_width: assert property (apb_rsp.pready && !apb_req.pwrite &&
                                   apb_req.paddr != AIE_OFF_CMD |-> apb_rsp.prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_status_form: assert property (apb_rsp.pready && !apb_req.pwrite &&
                                    apb_req.paddr == AIE_OFF_STATUS |->
                                    apb_rsp.prdata[31:9] == 23'h0 && !apb_rsp.prdata[7] &&
                                    apb_rsp.prdata[5])
    else $error("status form wrong");
  chk_wdt_pulse: assert property ($rose(wdt_expired) |=> !wdt_expired [*8])
    else $error("watchdog pulse too long or too close");
endmodule

bind aie_execute aie_execute_asserts #(.WDT_W(WDT_W), .RF_N(RF_N)) aie_execute_asserts_inst (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .wdt_expired(wdt_expired));
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import aie_pkg::*;

  localparam logic [7:0] AC = 8'h04, ST = 8'h08, R1 = 8'h24, R2 = 8'h28, R3 = 8'h2c, R4 = 8'h30;
  logic         pclk;
  logic         presetn;
  aie_apb_req_t req;
  aie_apb_rsp_t rsp;
  logic         wdt_expired;
  logic [31:0]  rdat;
  logic         rerr;
  logic [10:0]  pc_exp;
  logic [10:0]  link_exp;
  int           err_count;
  int           check_count;
  int           fl_exp;
  int           wdt_seen;

  // watchdog stays quiet through the instruction tests, yet wraps twice in the wdt test
  aie_execute #(.WDT_W(11), .RF_N(AIE_RF_N)) aie_execute_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .wdt_expired(wdt_expired));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (wdt_expired === 1'b1) wdt_seen++;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("ERROR pready expected 1 seen 0");
      err_count++;
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  function automatic logic [31:0] cm(logic [4:0] o, logic t = 0, logic [2:0] r = 0,
                                     logic [7:0] i = 0, logic [2:0] b = 0, logic [10:0] g = 0);
    return {1'b0, g, i, r, b, t, o};
  endfunction

  // issue one instruction, then check its result, the flags and the program counter
  task automatic ex(logic [31:0] c, logic [7:0] a, logic [7:0] v, logic [7:0] st);
    if (c[4:0] == AIE_OP_CALL) link_exp = pc_exp + 11'h001;
    if (c[4:0] inside {[5'h08:5'h0c]}) fl_exp++;
    if (c[4:0] inside {AIE_OP_CALL, AIE_OP_JUMP}) pc_exp = c[30:20];
    else if (c[4:0] inside {[5'h0a:5'h0c]}) pc_exp = link_exp;
    else pc_exp++;
    xfer(1, AIE_OFF_CMD, c);
    xfer(0, a, 0);
    chk("result", {24'h0, v}, rdat);
    xfer(0, ST, 0);
    chk("status", {24'h0, st}, rdat);
    xfer(0, AIE_OFF_PC, 0);
    chk("pc", {21'h0, pc_exp}, rdat);
  endtask

  task automatic t_reset();
    xfer(0, AC, 0);
    chk("accumulator", 0, rdat);
    xfer(0, ST, 0);
    chk("status", 32'h30, rdat);
    xfer(0, AIE_OFF_LINK, 0);
    chk("link", 0, rdat);
    xfer(1, 8'h3c, 32'h5a);
    xfer(0, 8'h3c, 0);
    chk("reg7", 32'h5a, rdat);
    xfer(1, ST, 0);
    xfer(0, ST, 0);
    chk("status ro", 32'h30, rdat);
    xfer(0, 8'h1c, 0);
    chk("hole err", 1, rerr);
    xfer(1, 8'h06, 32'h1);
    chk("misaligned err", 1, rerr);
    $display("test reset done");
  endtask

  task automatic t_arith();
    ex(cm(5'h15, 0, 0, 8'h09), AC, 8'h09, 8'h30);
    ex(cm(5'h14, 0, 1), R1, 8'h09, 8'h30);
    ex(cm(5'h15, 0, 0, 8'h77), AC, 8'h77, 8'h30);
    ex(cm(5'h01, 0, 1), AC, 8'h80, 8'h3a);
    ex(cm(5'h02, 1, 1), R1, 8'h89, 8'h30);
    ex(cm(5'h03, 0, 0, 8'hff), AC, 8'h7f, 8'h39);
    ex(cm(5'h02, 0, 1), AC, 8'h09, 8'h33);
    ex(cm(5'h03, 0, 0, 8'hf7), AC, 8'h00, 8'h37);
    $display("test arith done");
  endtask

  task automatic t_logic();
    ex(cm(5'h15, 0, 0, 8'h0f), AC, 8'h0f, 8'h37);
    ex(cm(5'h14, 0, 2), R2, 8'h0f, 8'h37);
    ex(cm(5'h15, 0, 0, 8'h77), AC, 8'h77, 8'h37);
    ex(cm(5'h04, 0, 2), AC, 8'h07, 8'h33);
    ex(cm(5'h04, 1, 2), R2, 8'h07, 8'h33);
    ex(cm(5'h05, 0, 0, 8'h00), AC, 8'h00, 8'h37);
    ex(cm(5'h06, 1, 2), R2, 8'h07, 8'h33);
    ex(cm(5'h07, 0, 0, 8'h30), AC, 8'h30, 8'h33);
    ex(cm(5'h06, 0, 2), AC, 8'h37, 8'h33);
    $display("test logic done");
  endtask

  task automatic t_unary();
    ex(cm(5'h10, 0, 2), AC, 8'hf8, 8'h33);
    ex(cm(5'h10, 1, 2), R2, 8'hf8, 8'h33);
    ex(cm(5'h12, 1, 2), R2, 8'hf9, 8'h33);
    ex(cm(5'h11, 0, 2), AC, 8'hf8, 8'h33);
    ex(cm(5'h15, 0, 0, 8'hff), AC, 8'hff, 8'h33);
    ex(cm(5'h14, 0, 3), R3, 8'hff, 8'h33);
    ex(cm(5'h12, 1, 3), R3, 8'h00, 8'h37);
    ex(cm(5'h11, 0, 3), AC, 8'hff, 8'h33);
    ex(cm(5'h13, 0, 3), AC, 8'h00, 8'h37);
    ex(cm(5'h0e, 1, 2, 0, 3'h7), R2, 8'h79, 8'h37);
    ex(cm(5'h13, 0, 2), AC, 8'h79, 8'h33);
    ex(cm(5'h0d, 0), AC, 8'h00, 8'h37);
    ex(cm(5'h0d, 1, 2), R2, 8'h00, 8'h37);
    $display("test unary done");
  endtask

  task automatic t_rotate();
    ex(cm(5'h15, 0, 0, 8'h03), AC, 8'h03, 8'h37);
    ex(cm(5'h14, 0, 4), R4, 8'h03, 8'h37);
    ex(cm(5'h16, 0, 4), AC, 8'h07, 8'h36);
    ex(cm(5'h17, 0, 4), AC, 8'h01, 8'h37);
    ex(cm(5'h17, 1, 4), R4, 8'h81, 8'h37);
    ex(cm(5'h16, 1, 4), R4, 8'h03, 8'h37);
    ex(cm(5'h18, 0, 4), AC, 8'h06, 8'h37);
    ex(cm(5'h19, 1, 4), R4, 8'h81, 8'h37);
    ex(cm(5'h18, 1, 4), R4, 8'h03, 8'h37);
    ex(cm(5'h19, 0, 4), AC, 8'h81, 8'h37);
    $display("test rotate done");
  endtask

  task automatic t_transfer();
    ex(cm(5'h09, 0, 0, 0, 0, 11'h123), AC, 8'h81, 8'h37);
    ex(cm(5'h08, 0, 0, 0, 0, 11'h200), AC, 8'h81, 8'h37);
    ex(cm(5'h0b, 0, 0, 8'h35), AC, 8'h35, 8'h37);
    ex(cm(5'h08, 0, 0, 0, 0, 11'h300), AC, 8'h35, 8'h37);
    xfer(0, AIE_OFF_LINK, 0);
    chk("link", {21'h0, link_exp}, rdat);
    ex(cm(5'h0a), AC, 8'h35, 8'h37);
    ex(cm(5'h0c), AC, 8'h35, 8'h77);
    xfer(0, AIE_OFF_FLUSH, 0);
    chk("flush count", fl_exp, rdat);
    $display("test transfer done");
  endtask

  task automatic t_wdt();
    xfer(1, AIE_OFF_CMD, cm(5'h0f));
    xfer(0, AIE_OFF_WDT, 0);
    chk("wdt cleared", 1, rdat < 32'h8);
    xfer(0, ST, 0);
    chk("status", 32'h77, rdat);
    wdt_seen = 0;
    repeat (4200) @(posedge pclk);
    chk("wdt wraps", 1, wdt_seen >= 2);
    xfer(0, ST, 0);
    chk("status after wrap", 32'h67, rdat);
    $display("test wdt done");
  endtask

  initial begin
    req = '0;
    presetn = 1'b0;
    err_count = 0;
    check_count = 0;
    pc_exp = '0;
    link_exp = '0;
    fl_exp = 0;
    wdt_seen = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    t_logic();
    t_unary();
    t_rotate();
    t_transfer();
    t_wdt();
    give_verdict();
  end

  // the whole sequence needs about 5000 cycles, mostly the two watchdog wraps
  initial begin
    #100000;
    $display("ERROR watchdog expected done seen hang");
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
